//--- core/frame_timing_pkg.sv
// Purpose: shared constants and types of the frame and exposure timing block
// Assumes: registers sit at byte address = 4 * index on an APB bus
// Notes: reset values are plain defaults for a nominal setup
package frame_timing_pkg;
	localparam int unsigned ADDR_W = 7;
	// register indices, byte address is the index times four
	localparam logic [4:0] IDX_TIME_UNIT = 5'h05;
	localparam logic [4:0] IDX_SCALE = 5'h07;
	localparam logic [4:0] IDX_FLOOR = 5'h08;
	localparam logic [4:0] IDX_GLOB = 5'h0A;
	localparam logic [4:0] IDX_MODE = 5'h0B;
	localparam logic [4:0] IDX_DUAL = 5'h0C;
	localparam logic [4:0] IDX_GROUP = 5'h0D;
	localparam logic [4:0] IDX_EXP_L = 5'h0E;
	localparam logic [4:0] IDX_EXP_S = 5'h10;
	localparam logic [4:0] IDX_STATUS = 5'h11;
	localparam logic [4:0] IDX_IMAGE = 5'h12;
	// values after reset
	localparam logic [13:0] RST_TIME_UNIT = 14'h00D0;
	localparam logic [7:0] RST_SCALE = 8'h00;
	localparam logic [15:0] RST_FLOOR = 16'h1388;
	localparam logic [15:0] RST_GLOB = 16'h0001;
	localparam logic [15:0] RST_EXP = 16'h03E8;
	// dummy rows between sampling and readout, and pixel period numerators
	localparam logic [2:0] DUMMY_SMALL_WIN = 3'h3;
	localparam logic [2:0] DUMMY_OTHER = 3'h7;
	localparam logic [3:0] PERIOD_NUM_10BIT = 4'hA;
	localparam logic [3:0] PERIOD_NUM_12BIT = 4'hC;

	typedef enum logic [2:0] {
		MODE_FULL_EXT = 3'h0,
		MODE_PROG_EXT = 3'h1,
		MODE_TRIGGERED = 3'h2,
		MODE_STREAMING = 3'h3
	} mode_e;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXPOSE = 4'b0010,
		ST_GLOB = 4'b0100,
		ST_READ = 4'b1000
	} state_e;

	typedef struct packed {
		logic [13:0] time_unit_length;
		logic [7:0] global_sample_scale;
		logic [15:0] frame_period_floor;
		logic [15:0] global_sample_duration;
		logic [2:0] sensor_control_select;
		logic two_exposure_enable;
		logic row_pair_grouping;
		logic [15:0] long_group_exposure;
		logic [15:0] short_group_exposure;
		logic small_window_10bit_mode;
		logic twelve_bit_output;
	} cfg_s;

	typedef struct packed {
		logic frame_start;
		logic expose_long;
		logic expose_short;
		logic glob_active;
		logic readout_active;
	} timing_s;
endpackage

//--- core/frame_exposure_timing_ctrl.sv
// Purpose: frame time and exposure time generator with dual exposure support
// Assumes: one clock pclk at 250 MHz; request pins are asynchronous
// Notes: APB slave with zero wait states; read data loaded in the setup cycle
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module frame_exposure_timing_ctrl
	import frame_timing_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic exposure_request,
	input wire logic frame_request,
	input wire logic [1:0] row_index_lsb,
	output timing_s timing,
	output logic [15:0] row_exposure_time,
	output logic [2:0] dummy_rows,
	output logic [3:0] pixel_period_num
);
	cfg_s cfg_q, cfg_d;
	logic [31:0] rdata_q, rdata_d;
	logic [2:0] exp_sync_q, exp_sync_d, frm_sync_q, frm_sync_d;
	logic [13:0] pre_q, pre_d;
	logic [16:0] cnt_q, cnt_d;
	state_e st_q, st_d;
	timing_s tim_q, tim_d;
	logic [15:0] row_exp_q, row_exp_d;
	logic [2:0] dummy_q, dummy_d;
	logic [3:0] period_q, period_d;
	logic [4:0] idx;
	logic wr_en, rd_setup, mapped;
	logic tick, exp_rise, exp_fall, frm_rise, full_ext, start_int;
	logic [15:0] exp_s_eff, max_exp;
	logic [16:0] cnt_inc, glob_end, frame_len;

	// true when the short group of four holds this row
	function automatic logic row_is_short(input logic [1:0] lsb, input logic paired);
		return paired ? !lsb[1] : !lsb[0];
	endfunction

	function automatic logic [16:0] max17(input logic [16:0] a, input logic [16:0] b);
		return (a > b) ? a : b;
	endfunction

	// address decode; misaligned addresses count as unmapped
	assign idx = paddr[6:2];
	always_comb begin
		mapped = (paddr[1:0] == 2'h0);
		if (idx == IDX_TIME_UNIT || idx == IDX_SCALE || idx == IDX_FLOOR) begin
			mapped = mapped;
		end else if (idx == IDX_GLOB || idx == IDX_MODE || idx == IDX_DUAL) begin
			mapped = mapped;
		end else if (idx == IDX_GROUP || idx == IDX_EXP_L || idx == IDX_EXP_S) begin
			mapped = mapped;
		end else if (idx == IDX_STATUS || idx == IDX_IMAGE) begin
			mapped = mapped;
		end else begin
			mapped = 1'b0;
		end
	end

	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_q;

	// register writes and read data; the status word is read only
	always_comb begin
		cfg_d = cfg_q;
		rdata_d = rdata_q;
		if (wr_en) begin
			if (idx == IDX_TIME_UNIT) begin
				cfg_d.time_unit_length = pwdata[13:0];
			end else if (idx == IDX_SCALE) begin
				cfg_d.global_sample_scale = pwdata[7:0];
			end else if (idx == IDX_FLOOR) begin
				cfg_d.frame_period_floor = pwdata[15:0];
			end else if (idx == IDX_GLOB) begin
				cfg_d.global_sample_duration = pwdata[15:0];
			end else if (idx == IDX_MODE) begin
				cfg_d.sensor_control_select = pwdata[2:0];
			end else if (idx == IDX_DUAL) begin
				cfg_d.two_exposure_enable = pwdata[0];
			end else if (idx == IDX_GROUP) begin
				cfg_d.row_pair_grouping = pwdata[0];
			end else if (idx == IDX_EXP_L) begin
				cfg_d.long_group_exposure = pwdata[15:0];
			end else if (idx == IDX_EXP_S) begin
				cfg_d.short_group_exposure = pwdata[15:0];
			end else if (idx == IDX_IMAGE) begin
				cfg_d.small_window_10bit_mode = pwdata[0];
				cfg_d.twelve_bit_output = pwdata[1];
			end
		end
		if (rd_setup) begin
			rdata_d = 32'h0000_0000;
			if (!mapped) begin
				rdata_d = 32'h0000_0000;
			end else if (idx == IDX_TIME_UNIT) begin
				rdata_d[13:0] = cfg_q.time_unit_length;
			end else if (idx == IDX_SCALE) begin
				rdata_d[7:0] = cfg_q.global_sample_scale;
			end else if (idx == IDX_FLOOR) begin
				rdata_d[15:0] = cfg_q.frame_period_floor;
			end else if (idx == IDX_GLOB) begin
				rdata_d[15:0] = cfg_q.global_sample_duration;
			end else if (idx == IDX_MODE) begin
				rdata_d[2:0] = cfg_q.sensor_control_select;
			end else if (idx == IDX_DUAL) begin
				rdata_d[0] = cfg_q.two_exposure_enable;
			end else if (idx == IDX_GROUP) begin
				rdata_d[0] = cfg_q.row_pair_grouping;
			end else if (idx == IDX_EXP_L) begin
				rdata_d[15:0] = cfg_q.long_group_exposure;
			end else if (idx == IDX_EXP_S) begin
				rdata_d[15:0] = cfg_q.short_group_exposure;
			end else if (idx == IDX_STATUS) begin
				// counter top bit left out so the word stays 32 bits wide
				rdata_d = {7'h00, tim_q, st_q, cnt_q[15:0]};
			end else begin
				rdata_d[1:0] = {cfg_q.twelve_bit_output, cfg_q.small_window_10bit_mode};
			end
		end
	end

	// pins pass two flops; edges are taken between the second and third
	assign exp_sync_d = {exp_sync_q[1:0], exposure_request};
	assign frm_sync_d = {frm_sync_q[1:0], frame_request};
	assign exp_rise = exp_sync_q[1] && !exp_sync_q[2];
	assign exp_fall = !exp_sync_q[1] && exp_sync_q[2];
	assign frm_rise = frm_sync_q[1] && !frm_sync_q[2];

	// prescaler: a unit of zero is served as one cycle so the tick never stops
	assign tick = (pre_q >= cfg_q.time_unit_length - 14'h0001) || (cfg_q.time_unit_length == 14'h0000);
	assign pre_d = tick ? 14'h0000 : 14'(pre_q + 14'h0001);

	// frame length: floor, or exposure (none in full external mode) plus sampling when that is longer
	assign full_ext = (cfg_q.sensor_control_select == MODE_FULL_EXT);
	assign exp_s_eff = cfg_q.two_exposure_enable ? cfg_q.short_group_exposure
		: cfg_q.long_group_exposure;
	assign max_exp = 16'(max17({1'b0, cfg_q.long_group_exposure}, {1'b0, exp_s_eff}));
	assign glob_end = (full_ext ? 17'h00000 : {1'b0, max_exp})
		+ {1'b0, cfg_q.global_sample_duration};
	assign frame_len = max17({1'b0, cfg_q.frame_period_floor}, glob_end);
	assign cnt_inc = 17'(cnt_q + 17'h00001);

	// mode 1 starts on the frame pin, mode 2 on the exposure pin, mode 3 free
	always_comb begin
		case (cfg_q.sensor_control_select)
			MODE_PROG_EXT: start_int = frm_rise;
			MODE_TRIGGERED: start_int = exp_rise;
			MODE_STREAMING: start_int = 1'b1;
			default: start_int = 1'b0;
		endcase
	end

	// frame sequencer; the counter only moves on prescaler ticks, except that idle clears it every cycle
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		tim_d = tim_q;
		tim_d.frame_start = 1'b0;
		case (st_q)
			ST_IDLE: begin
				cnt_d = 17'h00000;
				if (full_ext) begin
					if (exp_rise) begin
						tim_d.expose_long = 1'b1;
						tim_d.expose_short = !cfg_q.two_exposure_enable;
					end
					if (exp_fall && cfg_q.two_exposure_enable) begin
						tim_d.expose_short = 1'b1;
					end
					if (frm_rise) begin
						st_d = ST_GLOB;
						tim_d = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
					end
				end else if (start_int) begin
					st_d = ST_EXPOSE;
					tim_d = '{1'b1, cfg_q.long_group_exposure != 16'h0000,
						exp_s_eff != 16'h0000, 1'b0, 1'b0};
				end
			end
			ST_EXPOSE: begin
				if (tick) begin
					cnt_d = cnt_inc;
					tim_d.expose_long = cnt_inc < {1'b0, cfg_q.long_group_exposure};
					tim_d.expose_short = cnt_inc < {1'b0, exp_s_eff};
					if (cnt_inc >= {1'b0, max_exp}) begin
						st_d = ST_GLOB;
						tim_d.glob_active = 1'b1;
					end
				end
			end
			ST_GLOB: begin
				if (tick) begin
					cnt_d = cnt_inc;
					if (cnt_inc >= glob_end) begin
						st_d = ST_READ;
						tim_d.glob_active = 1'b0;
						tim_d.readout_active = 1'b1;
					end
				end
			end
			ST_READ: begin
				if (tick) begin
					cnt_d = cnt_inc;
					if (cnt_inc >= frame_len) begin
						tim_d.readout_active = 1'b0;
						if (cfg_q.sensor_control_select == MODE_STREAMING) begin
							st_d = ST_EXPOSE;
							cnt_d = 17'h00000;
							tim_d = '{1'b1, cfg_q.long_group_exposure != 16'h0000,
								exp_s_eff != 16'h0000, 1'b0, 1'b0};
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
				tim_d = '0;
			end
		endcase
	end

	// row exposure lookup and image mode dependent figures
	always_comb begin
		row_exp_d = row_is_short(row_index_lsb, cfg_q.row_pair_grouping) ? exp_s_eff
			: cfg_q.long_group_exposure;
		dummy_d = cfg_q.small_window_10bit_mode ? DUMMY_SMALL_WIN : DUMMY_OTHER;
		period_d = cfg_q.twelve_bit_output ? PERIOD_NUM_12BIT : PERIOD_NUM_10BIT;
	end

	// all state registers; configuration returns to its defaults on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= '{RST_TIME_UNIT, RST_SCALE, RST_FLOOR, RST_GLOB, MODE_FULL_EXT,
				1'b0, 1'b0, RST_EXP, RST_EXP, 1'b0, 1'b0};
			rdata_q <= 32'h0000_0000;
			exp_sync_q <= 3'h0;
			frm_sync_q <= 3'h0;
			pre_q <= 14'h0000;
			cnt_q <= 17'h00000;
			st_q <= ST_IDLE;
			tim_q <= '0;
			row_exp_q <= 16'h0000;
			dummy_q <= DUMMY_OTHER;
			period_q <= PERIOD_NUM_10BIT;
		end else begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
			exp_sync_q <= exp_sync_d;
			frm_sync_q <= frm_sync_d;
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			st_q <= st_d;
			tim_q <= tim_d;
			row_exp_q <= row_exp_d;
			dummy_q <= dummy_d;
			period_q <= period_d;
		end
	end

	assign timing = tim_q;
	assign row_exposure_time = row_exp_q;
	assign dummy_rows = dummy_q;
	assign pixel_period_num = period_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence ext_idle_s;
		st_q == ST_IDLE && full_ext && !frm_rise;
	endsequence
	sequence single_rise_s;
		ext_idle_s and (exp_rise && !cfg_q.two_exposure_enable);
	endsequence

	cnt_hold_a: assert property (!tick && st_q != ST_IDLE && st_q != ST_READ |=> $stable(cnt_q))
		else $error("frame counter moved without a tick");
	tick_wrap_a: assert property (tick |=> pre_q == 14'h0000)
		else $error("prescaler did not wrap on tick");
	ext_frame_a: assert property (st_q == ST_IDLE && full_ext && frm_rise |=> st_q == ST_GLOB && tim_q.frame_start)
		else $error("external frame request not taken");
	long_rise_a: assert property (ext_idle_s and exp_rise |=> tim_q.expose_long)
		else $error("rising request did not start long group");
	short_fall_a: assert property (ext_idle_s and (exp_fall && cfg_q.two_exposure_enable) |=> tim_q.expose_short)
		else $error("falling request did not start short group");
	both_rise_a: assert property (single_rise_s |=> tim_q.expose_long && tim_q.expose_short)
		else $error("single exposure did not start both groups");
	frame_stretch_a: assert property (st_q == ST_READ && tick && cnt_inc < frame_len |=> st_q == ST_READ)
		else $error("readout ended before stretched frame length");
	frame_floor_a: assert property (frame_len >= {1'b0, cfg_q.frame_period_floor} && frame_len >= glob_end)
		else $error("frame length below floor or exposure");
	group_map_a: assert property (row_index_lsb == 2'h1 |=> row_exp_q == ($past(cfg_q.row_pair_grouping) ? $past(exp_s_eff) : $past(cfg_q.long_group_exposure)))
		else $error("row group mapping wrong");
	dummy_count_a: assert property (##1 dummy_q == ($past(cfg_q.small_window_10bit_mode) ? 3'h3 : 3'h7))
		else $error("dummy row count wrong");
	single_exp_a: assert property (!cfg_q.two_exposure_enable |-> exp_s_eff == cfg_q.long_group_exposure)
		else $error("short group not following long time");
endmodule // frame_exposure_timing_ctrl

//--- verif/camera_ctrl_model.sv
// Purpose: external camera controller, APB master and request pins
// Assumes: pready sampled at a rising edge, any number of wait states
// Notes: setup values are worked out the way the controller must
`timescale 1ns/1ps
module camera_ctrl_model
	import frame_timing_pkg::*;
(
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic exposure_request,
	output logic frame_request
);
	logic last_err;

	// bus and pins quiet from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		exposure_request = 1'b0;
		frame_request = 1'b0;
		last_err = 1'b0;
	end

	// one transfer, request held until pready is seen high at a rising edge
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// request pin levels; a rise then a fall orders long before short
	task automatic pin(input logic e, input logic f);
		@(posedge pclk);
		exposure_request <= e;
		frame_request <= f;
	endtask

	// sampling length in units, rounded up; redone whenever the unit changes
	function automatic logic [15:0] glob_ticks(input logic [15:0] len, input logic [7:0] sc,
		input logic [13:0] unit);
		return 16'((32'(len) * 32'(sc) + 32'(unit) - 32'h1) / 32'(unit));
	endfunction

	// scale factor rounded down from base over pixel period
	function automatic logic [7:0] scale_of(input logic [15:0] base_ns, input logic [7:0] per);
		return 8'(base_ns / 16'(per));
	endfunction
endmodule // camera_ctrl_model

//--- verif/frame_exposure_timing_ctrl_test.sv
// Purpose: self-checking bench of the frame and exposure timing block
// Assumes: image bits register at its own index; the block answers with zero wait
// Notes: small time units keep frames short; fixed seed repeats runs
`timescale 1ns/1ps
module frame_exposure_timing_ctrl_test
	import frame_timing_pkg::*;
;
	localparam int NREG = 9;
	localparam logic [4:0] IDX_T [NREG] = '{IDX_TIME_UNIT, IDX_SCALE, IDX_FLOOR, IDX_GLOB,
		IDX_MODE, IDX_DUAL, IDX_GROUP, IDX_EXP_L, IDX_EXP_S};
	localparam logic [31:0] RST_T [NREG] = '{32'(RST_TIME_UNIT), 32'(RST_SCALE),
		32'(RST_FLOOR), 32'(RST_GLOB), 32'h0, 32'h0, 32'h0, 32'(RST_EXP), 32'(RST_EXP)};
	localparam logic [31:0] MSK_T [NREG] = '{32'h3FFF, 32'hFF, 32'hFFFF, 32'hFFFF, 32'h7,
		32'h1, 32'h1, 32'hFFFF, 32'hFFFF};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exposure_request, frame_request;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, v, r;
	logic [1:0] row_index_lsb;
	timing_s timing;
	logic [15:0] row_exposure_time, lg, sh, g, fl;
	logic [2:0] dummy_rows;
	logic [3:0] pixel_period_num;
	logic [13:0] u;
	int fail_count, n_tests, n, m;

	frame_exposure_timing_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exposure_request(exposure_request),
		.frame_request(frame_request), .row_index_lsb(row_index_lsb), .timing(timing),
		.row_exposure_time(row_exposure_time), .dummy_rows(dummy_rows),
		.pixel_period_num(pixel_period_num));

	camera_ctrl_model i_ctrl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exposure_request(exposure_request), .frame_request(frame_request));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (fail_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [4:0] idx, input logic [31:0] d);
		logic [31:0] unused;
		i_ctrl.xfer(1'b1, {idx, 2'b00}, d, unused);
	endtask

	task automatic rd(input logic [4:0] idx, output logic [31:0] d);
		i_ctrl.xfer(1'b0, {idx, 2'b00}, 32'h0, d);
	endtask

	// mid-run reset, also restores every register default
	task automatic hard_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// bounded wait for one timing bit, sampled where outputs are settled
	task automatic wait_for(input int b);
		for (int c = 0; c < 500 && timing[b] !== 1'b1; c++) @(negedge pclk);
	endtask

	// the first frame starts at any prescaler phase, so the second one is timed
	task automatic period(output int cnt);
		wait_for(4);
		@(negedge pclk);
		wait_for(4);
		cnt = 0;
		do begin
			@(negedge pclk);
			cnt++;
		end while (timing.frame_start !== 1'b1 && cnt < 3000);
	endtask

	// short rows take the short time only while dual exposure is on
	function automatic logic [15:0] exp_row(input logic d, input logic gp, input logic [1:0] ri,
		input logic [15:0] l, input logic [15:0] s);
		logic short_row;
		short_row = gp ? !ri[1] : !ri[0];
		return (d && short_row) ? s : l;
	endfunction

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// a hang costs far more than the few hundred cycles the run needs
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end

	initial begin
		presetn = 1'b0;
		row_index_lsb = 2'h0;
		fail_count = 0;
		n_tests = 0;
		void'($urandom(90880));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// defaults, then random words read back through each field width
		for (int i = 0; i < NREG; i++) begin
			rd(IDX_T[i], v);
			check("reset value", v, RST_T[i]);
			r = $urandom();
			wr(IDX_T[i], r);
			rd(IDX_T[i], v);
			check("read back", v, r & MSK_T[i]);
		end
		// unmapped and misaligned places answer with an error and zero
		for (int i = 0; i < 2; i++) begin
			i_ctrl.xfer(1'b0, i ? 7'h15 : 7'h7C, 32'h0, v);
			check("error read", v, 32'h0);
			check("error flag", 32'(i_ctrl.last_err), 32'h1);
		end
		hard_reset();
		// idle after reset: state one-hot idle, counter and timing clear
		rd(IDX_STATUS, v);
		check("status idle", v, 32'h0001_0000);
		for (int k = 0; k < 4; k++) begin
			wr(IDX_IMAGE, 32'(k));
			repeat (2) @(posedge pclk);
			check("dummy rows", 32'(dummy_rows), k[0] ? 32'h3 : 32'h7);
			check("period num", 32'(pixel_period_num), k[1] ? 32'hC : 32'hA);
		end
		// every grouping, with the long time kept below the short one
		for (int k = 0; k < 4; k++) begin
			lg = 16'($urandom_range(1, 900));
			sh = lg + 16'($urandom_range(1, 900));
			wr(IDX_DUAL, 32'(k[0]));
			wr(IDX_GROUP, 32'(k[1]));
			wr(IDX_EXP_L, 32'(lg));
			wr(IDX_EXP_S, 32'(sh));
			repeat (8) begin
				row_index_lsb <= 2'($urandom());
				repeat (2) @(posedge pclk);
				check("row time", 32'(row_exposure_time),
					32'(exp_row(k[0], k[1], row_index_lsb, lg, sh)));
			end
		end
		// an undefined mode stays idle whatever the pins do
		wr(IDX_MODE, 32'h5);
		i_ctrl.pin(1'b1, 1'b1);
		repeat (12) @(posedge pclk);
		check("idle timing", 32'(timing), 32'h0);
		i_ctrl.pin(1'b0, 1'b0);
		for (m = 1; m < 3; m++) begin
			hard_reset();
			wr(IDX_MODE, 32'(m));
			i_ctrl.pin(m == 2, m == 1);
			wait_for(3);
			check("mode start", 32'(timing.expose_long), 32'h1);
			i_ctrl.pin(1'b0, 1'b0);
		end
		// full external: short group follows the fall only with dual on
		for (int d = 0; d < 2; d++) begin
			hard_reset();
			wr(IDX_DUAL, 32'(d));
			i_ctrl.pin(1'b1, 1'b0);
			wait_for(3);
			check("short at rise", 32'(timing.expose_short), d ? 32'h0 : 32'h1);
			i_ctrl.pin(1'b0, 1'b0);
			if (d == 1) begin
				wait_for(2);
				check("short at fall", 32'(timing.expose_short), 32'h1);
			end
		end
		// streaming frame: floor wins first, then the exposure stretches it
		for (int k = 0; k < 2; k++) begin
			hard_reset();
			u = 14'($urandom_range(1, 4));
			g = i_ctrl.glob_ticks(16'h1, i_ctrl.scale_of(16'h28, 8'h4), u);
			lg = k ? 16'h9 : 16'h3;
			sh = k ? 16'h2 : 16'h5;
			fl = k ? 16'h4 : 16'h1E; // floor of 30 is above glob plus exposure
			wr(IDX_TIME_UNIT, 32'(u));
			wr(IDX_SCALE, 32'(i_ctrl.scale_of(16'h28, 8'h4)));
			wr(IDX_GLOB, 32'(g));
			wr(IDX_FLOOR, 32'(fl));
			wr(IDX_EXP_L, 32'(lg));
			wr(IDX_EXP_S, 32'(sh));
			wr(IDX_DUAL, 32'h1);
			wr(IDX_MODE, 32'h3);
			period(n);
			// readout always takes at least one unit after the sampling phase
			m = int'((lg > sh ? lg : sh) + g) + 1;
			m = int'(u) * (int'(fl) > m ? int'(fl) : m);
			check("frame cycles", 32'(n), 32'(m));
		end
		end_of_test();
	end
endmodule // frame_exposure_timing_ctrl_test
